// ===== design/ppi_pin_sync.sv
/*
 * Two-stage pin synchroniser with previous-sample edge detection.
 * Assumes pins are asynchronous to i_ref_clk; o_edge is combinational
 * from flops and is meant for logic on the same clock only.
 */
module ppi_pin_sync #(
    parameter int W = 8
) (
    input  wire logic         i_ref_clk,
    input  wire logic         i_resetn,
    input  wire logic [W-1:0] i_pin,
    input  wire logic [W-1:0] i_pol,
    output logic      [W-1:0] o_level,
    output logic      [W-1:0] o_edge
);

    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] lvl;
        logic [W-1:0] prev;
    } ppi_sync_t;

    ppi_sync_t r;
    ppi_sync_t next_r;

    ////////////////////////////////////////////////////////////////////////
    // The first stage feeds only the second stage, never any other logic.
    always_comb begin
        next_r      = r;
        next_r.meta = i_pin;
        next_r.lvl  = r.meta;
        next_r.prev = r.lvl;
    end

    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Polarity 1 picks rising edges, 0 picks falling edges.
    assign o_level = r.lvl;
    assign o_edge  = (i_pol & r.lvl & ~r.prev)
                   | (~i_pol & ~r.lvl & r.prev); // [R9]

endmodule : ppi_pin_sync

// ===== design/ppi_port.sv
/*
 * Port pin block: serial-port and analog-port data/direction/input
 * registers with serial pin takeover, and an eight-pin edge port with
 * per-pin enables, polarity and write-one-to-clear flags.
 * Assumes a single clock, a plain register port with read data one
 * cycle after the read strobe, and serial enables on the same clock.
 */
// Added by the designer: the address-and-strobe port.
// Overview of operation
// [R1] A data register read returns the stored bit where direction is 1 and the pin level elsewhere.
// [R2] Serial transmit pin 1 is forced to output and receive pin 0 to input while enabled.
// [R3] The input registers always return pin levels, low four bits for the serial port, ignoring writes.
// [R4] The input registers show the real pin level even on driven pins.
// [R5] Each of the eight edge pins has an interrupt enable, 0 masks and 1 permits.
// [R6] Each edge pin flag is set by an active edge chosen by the pin's polarity.
// [R7] Writing 1 to a flag bit clears it and writing 0 leaves it alone.
// [R8] The interrupt request is high while any flag and its enable are both set.
// [R9] Polarity 0 selects falling and 1 rising edges, against the previous sample.
// [R10] Reset clears all flags and enables, so no interrupt is pending.
module ppi_port #(
    parameter int SER_W  = ppi_pkg::SER_W,
    parameter int AD_W   = ppi_pkg::AD_W,
    parameter int EDGE_W = ppi_pkg::EDGE_W
) (
    input  wire logic              i_ref_clk,
    input  wire logic              i_resetn,
    input  wire logic [5:0]        i_addr,
    input  wire logic [7:0]        i_wdata,
    input  wire logic              i_wr,
    input  wire logic              i_rd,
    output logic      [7:0]        o_rdata,
    output logic                   o_irq,
    input  wire logic [SER_W-1:0]  i_ser_pin,
    output logic      [SER_W-1:0]  o_ser_out,
    output logic      [SER_W-1:0]  o_ser_oe_n,
    input  wire logic [AD_W-1:0]   i_ad_pin,
    output logic      [AD_W-1:0]   o_ad_out,
    output logic      [AD_W-1:0]   o_ad_oe_n,
    input  wire logic [EDGE_W-1:0] i_edge_pin,
    input  wire logic              i_sci_tx_en,
    input  wire logic              i_sci_rx_en,
    input  wire logic              i_sci_txd,
    output logic                   o_sci_rxd
);

    typedef struct packed {
        logic [SER_W-1:0]  ser_data;
        logic [SER_W-1:0]  ser_dir;
        logic [AD_W-1:0]   ad_data;
        logic [AD_W-1:0]   ad_dir;
        logic [EDGE_W-1:0] irq_en;
        logic [EDGE_W-1:0] pol;
        logic [EDGE_W-1:0] flags;
        logic [7:0]        rdata;
        logic              irq;
        logic [SER_W-1:0]  ser_out;
        logic [SER_W-1:0]  ser_oe_n;
        logic [AD_W-1:0]   ad_out;
        logic [AD_W-1:0]   ad_oe_n;
        logic              sci_rxd;
    } ppi_state_t;

    ppi_state_t r;
    ppi_state_t next_r;

    logic [SER_W-1:0]  ser_lvl;
    logic [AD_W-1:0]   ad_lvl;
    logic [EDGE_W-1:0] edge_lvl;
    logic [EDGE_W-1:0] edge_hit;
    logic [SER_W-1:0]  ser_eff_dir;
    logic [SER_W-1:0]  ser_drive;
    logic [7:0]        clr_mask;

    ////////////////////////////////////////////////////////////////////////
    // Widen a port value to the 8-bit bus, upper bits reading as zero.
    function automatic logic [7:0] widen(input logic [7:0] v, input int w);
        logic [7:0] m;
        m = 8'hff >> (8 - w);
        return v & m;
    endfunction : widen

    // Direction-dependent read of a port data register.
    function automatic logic [7:0] port_view(input logic [7:0] data,
                                             input logic [7:0] dir,
                                             input logic [7:0] lvl);
        return (dir & data) | (~dir & lvl); // [R1]
    endfunction : port_view

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers; only the edge port uses the edge outputs.
    ppi_pin_sync #(.W(SER_W)) u_ser_sync (
        .i_ref_clk (i_ref_clk),
        .i_resetn  (i_resetn),
        .i_pin     (i_ser_pin),
        .i_pol     ('0),
        .o_level   (ser_lvl),
        .o_edge    ()
    );

    ppi_pin_sync #(.W(AD_W)) u_ad_sync (
        .i_ref_clk (i_ref_clk),
        .i_resetn  (i_resetn),
        .i_pin     (i_ad_pin),
        .i_pol     ('0),
        .o_level   (ad_lvl),
        .o_edge    ()
    );

    ppi_pin_sync #(.W(EDGE_W)) u_edge_sync (
        .i_ref_clk (i_ref_clk),
        .i_resetn  (i_resetn),
        .i_pin     (i_edge_pin),
        .i_pol     (r.pol),
        .o_level   (edge_lvl),
        .o_edge    (edge_hit)
    );

    ////////////////////////////////////////////////////////////////////////
    // Serial takeover: the enables override the software direction.
    always_comb begin
        ser_eff_dir = r.ser_dir;
        ser_drive   = r.ser_data;
        if (i_sci_tx_en) begin
            ser_eff_dir[ppi_pkg::SER_TX_BIT] = 1'b1; // [R2]
            ser_drive[ppi_pkg::SER_TX_BIT]   = i_sci_txd;
        end
        if (i_sci_rx_en) begin
            ser_eff_dir[ppi_pkg::SER_RX_BIT] = 1'b0; // [R2]
        end
    end

    // Either the flag register or its clear alias clears with ones.
    assign clr_mask = (i_wr && (i_addr == ppi_pkg::OFS_IRQ_FLAGS
                               || i_addr == ppi_pkg::OFS_IRQ_CLR))
                      ? i_wdata : 8'h00;

    ////////////////////////////////////////////////////////////////////////
    // Next-state logic: register writes, flags, read data and pin drive.
    always_comb begin
        next_r = r;
        if (i_wr) begin
            case (i_addr)
                ppi_pkg::OFS_SER_DATA: next_r.ser_data = i_wdata[SER_W-1:0];
                ppi_pkg::OFS_SER_DIR:  next_r.ser_dir  = i_wdata[SER_W-1:0];
                ppi_pkg::OFS_AD_DATA:  next_r.ad_data  = i_wdata[AD_W-1:0];
                ppi_pkg::OFS_AD_DIR:   next_r.ad_dir   = i_wdata[AD_W-1:0];
                ppi_pkg::OFS_IRQ_EN:   next_r.irq_en   = i_wdata[EDGE_W-1:0];
                ppi_pkg::OFS_EDGE_POL: next_r.pol      = i_wdata[EDGE_W-1:0];
                default: begin
                    // Input registers and unmapped offsets ignore writes.
                end
            endcase // [R3]
        end
        // A new edge wins over a clear in the same cycle.
        next_r.flags = (r.flags & ~clr_mask[EDGE_W-1:0]) // [R7]
                     | edge_hit; // [R6]
        // Registered, so the request follows the flags by one cycle.
        next_r.irq = |(r.flags & r.irq_en); // [R8] [R5]
        next_r.rdata = 8'h00;
        if (i_rd) begin
            case (i_addr)
                ppi_pkg::OFS_SER_DATA:
                    next_r.rdata = widen(port_view(8'(r.ser_data),
                                         8'(r.ser_dir), 8'(ser_lvl)),
                                         SER_W); // [R1]
                ppi_pkg::OFS_SER_LVL:
                    next_r.rdata = widen(8'(ser_lvl), SER_W); // [R3] [R4]
                ppi_pkg::OFS_SER_DIR:
                    next_r.rdata = widen(8'(r.ser_dir), SER_W);
                ppi_pkg::OFS_IRQ_EN:    next_r.rdata = 8'(r.irq_en);
                ppi_pkg::OFS_EDGE_POL:  next_r.rdata = 8'(r.pol);
                ppi_pkg::OFS_IRQ_FLAGS: next_r.rdata = 8'(r.flags);
                ppi_pkg::OFS_AD_DATA:
                    next_r.rdata = widen(port_view(8'(r.ad_data),
                                         8'(r.ad_dir), 8'(ad_lvl)),
                                         AD_W); // [R1]
                ppi_pkg::OFS_AD_LVL:
                    next_r.rdata = widen(8'(ad_lvl), AD_W); // [R3] [R4]
                ppi_pkg::OFS_AD_DIR:
                    next_r.rdata = widen(8'(r.ad_dir), AD_W);
                default: next_r.rdata = 8'h00;
            endcase
        end
        next_r.ser_out  = ser_drive;
        next_r.ser_oe_n = ~ser_eff_dir; // [R2]
        next_r.ad_out   = r.ad_data;
        next_r.ad_oe_n  = ~r.ad_dir;
        next_r.sci_rxd  = ser_lvl[ppi_pkg::SER_RX_BIT];
    end

    ////////////////////////////////////////////////////////////////////////
    // State register; all pins float as inputs after reset.
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            r          <= '0;
            r.ser_data <= ppi_pkg::RST_DATA[SER_W-1:0];
            r.ser_dir  <= ppi_pkg::RST_DIR[SER_W-1:0];
            r.ad_data  <= ppi_pkg::RST_DATA[AD_W-1:0];
            r.ad_dir   <= ppi_pkg::RST_DIR[AD_W-1:0];
            r.irq_en   <= ppi_pkg::RST_IRQ_EN[EDGE_W-1:0]; // [R10]
            r.pol      <= ppi_pkg::RST_POL[EDGE_W-1:0];
            r.flags    <= ppi_pkg::RST_FLAGS[EDGE_W-1:0]; // [R10]
            r.ser_oe_n <= '1;
            r.ad_oe_n  <= '1;
        end else begin
            r <= next_r;
        end
    end

    assign o_rdata    = r.rdata;
    assign o_irq      = r.irq;
    assign o_ser_out  = r.ser_out;
    assign o_ser_oe_n = r.ser_oe_n;
    assign o_ad_out   = r.ad_out;
    assign o_ad_oe_n  = r.ad_oe_n;
    assign o_sci_rxd  = r.sci_rxd;

    ////////////////////////////////////////////////////////////////////////
    // Checks on the design's own behaviour.
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_resetn);

    property p_rd_port_view;
        i_rd && i_addr == ppi_pkg::OFS_AD_DATA
        |=> o_rdata == (($past(r.ad_dir) & $past(r.ad_data))
                       | (~$past(r.ad_dir) & $past(ad_lvl)));
    endproperty
    a_rd_port_view: assert property (p_rd_port_view) // [R1]
        else $error("port data read does not follow direction");

    property p_tx_force;
        i_sci_tx_en |=> !o_ser_oe_n[ppi_pkg::SER_TX_BIT]
                        && o_ser_out[ppi_pkg::SER_TX_BIT]
                           == $past(i_sci_txd);
    endproperty
    a_tx_force: assert property (p_tx_force) // [R2]
        else $error("transmit pin not driven by serial interface");

    property p_rx_force;
        i_sci_rx_en |=> o_ser_oe_n[ppi_pkg::SER_RX_BIT];
    endproperty
    a_rx_force: assert property (p_rx_force) // [R2]
        else $error("receive pin not released to input");

    property p_lvl_ro;
        i_wr && i_addr == ppi_pkg::OFS_SER_LVL
        |=> $stable(r.ser_data) && $stable(r.ser_dir);
    endproperty
    a_lvl_ro: assert property (p_lvl_ro) // [R3]
        else $error("write to input register changed state");

    property p_lvl_on_output;
        i_rd && i_addr == ppi_pkg::OFS_AD_LVL && r.ad_dir != '0
        |=> o_rdata == $past(ad_lvl)
            ##1 ($past(i_rd) || o_rdata == 8'h00);
    endproperty
    a_lvl_on_output: assert property (p_lvl_on_output) // [R4]
        else $error("input register does not show pin level");

    property p_masked;
        (r.flags & r.irq_en) == '0 |=> !o_irq;
    endproperty
    a_masked: assert property (p_masked) // [R5]
        else $error("masked flag raised interrupt");

    property p_edge_sets;
        |edge_hit |=> (r.flags & $past(edge_hit)) == $past(edge_hit);
    endproperty
    a_edge_sets: assert property (p_edge_sets) // [R6]
        else $error("active edge did not set its flag");

    property p_w1c;
        i_wr && i_addr == ppi_pkg::OFS_IRQ_FLAGS && edge_hit == '0
        |=> r.flags == ($past(r.flags) & ~$past(i_wdata));
    endproperty
    a_w1c: assert property (p_w1c) // [R7]
        else $error("flag clear did not follow written ones");

    property p_irq_on;
        |(r.flags & r.irq_en) |=> o_irq;
    endproperty
    a_irq_on: assert property (p_irq_on) // [R8]
        else $error("enabled flag did not raise interrupt");

    property p_polarity;
        (edge_hit & r.pol & ~(edge_lvl & ~$past(edge_lvl))) == '0;
    endproperty
    a_polarity: assert property (p_polarity) // [R9]
        else $error("rising-polarity pin flagged without a rise");

    property p_reset_clear;
        @(posedge i_ref_clk) !$past(i_resetn) && i_resetn
        |-> r.flags == '0 && r.irq_en == '0 && !o_irq;
    endproperty
    a_reset_clear: assert property (p_reset_clear) // [R10]
        else $error("flags or enables not cleared by reset");

    c_irq_raised: cover property (|edge_hit ##2 o_irq);
    c_flag_cleared: cover property (
        i_wr && i_addr == ppi_pkg::OFS_IRQ_FLAGS && (r.flags & i_wdata) != 0);
    c_tx_takeover: cover property (
        i_sci_tx_en && !r.ser_dir[ppi_pkg::SER_TX_BIT]);
    c_ad_read: cover property (i_rd && i_addr == ppi_pkg::OFS_AD_DATA);

endmodule : ppi_port

// ===== include/ppi_pkg.sv
/*
 * Constants shared by the port pin block: register offsets on the plain
 * byte-wide register port, reset values and port widths.
 * Assumes byte addressing with a 6-bit address and 8-bit data.
 */
package ppi_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Bus geometry.
    localparam int ADDR_W = 6;
    localparam int DATA_W = 8;

    ////////////////////////////////////////////////////////////////////////
    // Register offsets.
    localparam logic [5:0] OFS_SER_DATA  = 6'h08;
    localparam logic [5:0] OFS_SER_LVL   = 6'h09;
    localparam logic [5:0] OFS_SER_DIR   = 6'h0a;
    localparam logic [5:0] OFS_IRQ_EN    = 6'h1c;
    localparam logic [5:0] OFS_EDGE_POL  = 6'h1d;
    localparam logic [5:0] OFS_IRQ_CLR   = 6'h1e;
    localparam logic [5:0] OFS_IRQ_FLAGS = 6'h1f;
    localparam logic [5:0] OFS_AD_DATA   = 6'h30;
    localparam logic [5:0] OFS_AD_LVL    = 6'h31;
    localparam logic [5:0] OFS_AD_DIR    = 6'h32;

    ////////////////////////////////////////////////////////////////////////
    // Reset values and fixed bit positions.
    localparam logic [7:0] RST_DATA   = 8'h00;
    localparam logic [7:0] RST_DIR    = 8'h00;
    localparam logic [7:0] RST_IRQ_EN = 8'h00;
    localparam logic [7:0] RST_POL    = 8'h00;
    localparam logic [7:0] RST_FLAGS  = 8'h00;
    localparam int         SER_TX_BIT = 1;
    localparam int         SER_RX_BIT = 0;

    ////////////////////////////////////////////////////////////////////////
    // Port widths.
    localparam int SER_W  = 4;
    localparam int AD_W   = 8;
    localparam int EDGE_W = 8;

endpackage : ppi_pkg

// ===== sim/ppi_pin_model.sv
/*
 * Far-side model of the port pins: the outside world that drives each pin
 * when the block does not, and can overpower a driven pin to mimic a short.
 * Assumes the bench sets the external levels and short masks by NBA.
 */
module ppi_pin_model (
    input  wire logic [3:0] i_ser_out,
    input  wire logic [3:0] i_ser_oe_n,
    input  wire logic [7:0] i_ad_out,
    input  wire logic [7:0] i_ad_oe_n,
    input  wire logic [3:0] i_ext_ser,
    input  wire logic [7:0] i_ext_ad,
    input  wire logic [3:0] i_short_ser,
    input  wire logic [7:0] i_short_ad,
    output logic      [3:0] o_ser_pin,
    output logic      [7:0] o_ad_pin
);
    timeunit 1ns;
    timeprecision 1ps;

    // A driven pin shows the block's value unless a short wins; an
    // undriven pin always shows the outside level, never a stale value.
    assign o_ser_pin = (~i_ser_oe_n & ~i_short_ser & i_ser_out)
                     | ((i_ser_oe_n | i_short_ser) & i_ext_ser);
    assign o_ad_pin  = (~i_ad_oe_n & ~i_short_ad & i_ad_out)
                     | ((i_ad_oe_n | i_short_ad) & i_ext_ad);
endmodule : ppi_pin_model

// ===== sim/ppi_port_tb_top.sv
/*
 * Self-checking bench for the port pin block: register reads and writes
 * over the plain register port, pin levels through the far-side model.
 * Assumes the design's own assertions ride along inside its files.
 */
module ppi_port_tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    logic       i_ref_clk = 1'b0;
    logic       i_resetn  = 1'b0;
    logic [5:0] i_addr    = 6'h00;
    logic [7:0] i_wdata   = 8'h00;
    logic       i_wr      = 1'b0;
    logic       i_rd      = 1'b0;
    logic [7:0] o_rdata;
    logic       o_irq;
    logic [3:0] ser_pin, o_ser_out, o_ser_oe_n;
    logic [7:0] ad_pin, o_ad_out, o_ad_oe_n;
    logic [7:0] edge_pin  = 8'hf0;
    logic       tx_en     = 1'b0;
    logic       rx_en     = 1'b0;
    logic       txd       = 1'b1;
    logic       o_sci_rxd;
    logic [3:0] ext_ser   = 4'h5;
    logic [7:0] ext_ad    = 8'h5a;
    logic [3:0] short_ser = 4'h1;
    logic [7:0] short_ad  = 8'h01;
    int         n_mismatch = 0;
    int         checks_done = 0;

    // Clock at 50 MHz.
    always #10 i_ref_clk = ~i_ref_clk;

    ppi_port uut (.i_ref_clk(i_ref_clk), .i_resetn(i_resetn),
        .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
        .o_rdata(o_rdata), .o_irq(o_irq), .i_ser_pin(ser_pin),
        .o_ser_out(o_ser_out), .o_ser_oe_n(o_ser_oe_n),
        .i_ad_pin(ad_pin), .o_ad_out(o_ad_out), .o_ad_oe_n(o_ad_oe_n),
        .i_edge_pin(edge_pin), .i_sci_tx_en(tx_en), .i_sci_rx_en(rx_en),
        .i_sci_txd(txd), .o_sci_rxd(o_sci_rxd));

    ppi_pin_model far_side (.i_ser_out(o_ser_out), .i_ser_oe_n(o_ser_oe_n),
        .i_ad_out(o_ad_out), .i_ad_oe_n(o_ad_oe_n), .i_ext_ser(ext_ser),
        .i_ext_ad(ext_ad), .i_short_ser(short_ser), .i_short_ad(short_ad),
        .o_ser_pin(ser_pin), .o_ad_pin(ad_pin));

    ////////////////////////////////////////////////////////////////////////
    // Verdict, comparison and bus tasks.
    task automatic give_verdict;
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : give_verdict

    task automatic chk(input logic [7:0] got, input logic [7:0] exp,
                       input string what);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic idle(input int n);
        repeat (n) @(posedge i_ref_clk);
    endtask : idle

    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(posedge i_ref_clk);
        i_addr  <= a;
        i_wdata <= d;
        i_wr    <= 1'b1;
        @(posedge i_ref_clk);
        i_wr    <= 1'b0;
    endtask : wr

    // Read data stand only in the cycle after the strobe, so sample there.
    task automatic rd_chk(input logic [5:0] a, input logic [7:0] exp);
        @(posedge i_ref_clk);
        i_addr <= a;
        i_rd   <= 1'b1;
        @(posedge i_ref_clk);
        i_rd   <= 1'b0;
        #1;
        chk(o_rdata, exp, "read");
    endtask : rd_chk

    // A hang anywhere ends the run as a failure.
    initial begin
        idle(20000);
        n_mismatch++;
        give_verdict();
    end

    ////////////////////////////////////////////////////////////////////////
    // Main sequence.
    initial begin
        idle(20);
        i_resetn <= 1'b1;
        rd_chk(ppi_pkg::OFS_IRQ_FLAGS, 8'h00);
        rd_chk(ppi_pkg::OFS_IRQ_EN, 8'h00);
        chk({7'h00, o_irq}, 8'h00, "irq");
        rd_chk(6'h3f, 8'h00);
        // Analog port: low nibble driven, bit 0 shorted low from outside.
        wr(ppi_pkg::OFS_AD_DIR, 8'h0f);
        wr(ppi_pkg::OFS_AD_DATA, 8'h33);
        wr(ppi_pkg::OFS_AD_LVL, 8'hff);
        idle(4);
        #1;
        chk(o_ad_oe_n, 8'hf0, "ad oe");
        chk(o_ad_out, 8'h33, "ad out");
        rd_chk(ppi_pkg::OFS_AD_DATA, 8'h53);
        rd_chk(ppi_pkg::OFS_AD_LVL, 8'h52);
        // Serial port: bits 1:0 driven, bit 0 shorted high; the write to
        // the input register must leave data and direction untouched.
        wr(ppi_pkg::OFS_SER_DIR, 8'h03);
        wr(ppi_pkg::OFS_SER_DATA, 8'h0a);
        wr(ppi_pkg::OFS_SER_LVL, 8'hff);
        idle(4);
        rd_chk(ppi_pkg::OFS_SER_DATA, 8'h06);
        rd_chk(ppi_pkg::OFS_SER_LVL, 8'h07);
        // Takeover against the software direction: pin 1 is an input and
        // pin 0 an output, so both overrides really flip something.
        wr(ppi_pkg::OFS_SER_DIR, 8'h01);
        short_ser <= 4'h0;
        tx_en     <= 1'b1;
        rx_en     <= 1'b1;
        txd       <= 1'b0;
        idle(5);
        #1;
        chk({4'h0, o_ser_oe_n}, 8'h0d, "ser oe");
        chk({7'h00, o_ser_out[1]}, 8'h00, "txd");
        chk({7'h00, o_sci_rxd}, 8'h01, "rxd");
        @(posedge i_ref_clk);
        tx_en <= 1'b0;
        rx_en <= 1'b0;
        idle(3);
        #1;
        chk({4'h0, o_ser_oe_n}, 8'h0e, "ser oe");
        // Edge port: low nibble rising, high nibble falling.
        wr(ppi_pkg::OFS_EDGE_POL, 8'h0f);
        wr(ppi_pkg::OFS_IRQ_EN, 8'h81);
        rd_chk(ppi_pkg::OFS_IRQ_EN, 8'h81);
        @(posedge i_ref_clk);
        edge_pin <= 8'h0f;
        idle(6);
        rd_chk(ppi_pkg::OFS_IRQ_FLAGS, 8'hff);
        chk({7'h00, o_irq}, 8'h01, "irq");
        wr(ppi_pkg::OFS_IRQ_FLAGS, 8'h0f);
        rd_chk(ppi_pkg::OFS_IRQ_FLAGS, 8'hf0);
        chk({7'h00, o_irq}, 8'h01, "irq");
        wr(ppi_pkg::OFS_IRQ_FLAGS, 8'hf0);
        idle(2);
        #1;
        chk({7'h00, o_irq}, 8'h00, "irq");
        // Opposite edges on every pin must leave the flags alone.
        @(posedge i_ref_clk);
        edge_pin <= 8'hf0;
        idle(6);
        rd_chk(ppi_pkg::OFS_IRQ_FLAGS, 8'h00);
        // Masked flags still set but raise no request until enabled.
        wr(ppi_pkg::OFS_IRQ_EN, 8'h00);
        edge_pin <= 8'h0f;
        idle(6);
        rd_chk(ppi_pkg::OFS_IRQ_FLAGS, 8'hff);
        chk({7'h00, o_irq}, 8'h00, "irq");
        wr(ppi_pkg::OFS_IRQ_EN, 8'h02);
        idle(2);
        #1;
        chk({7'h00, o_irq}, 8'h01, "irq");
        wr(ppi_pkg::OFS_IRQ_CLR, 8'hff);
        idle(2);
        rd_chk(ppi_pkg::OFS_IRQ_FLAGS, 8'h00);
        rd_chk(ppi_pkg::OFS_IRQ_CLR, 8'h00);
        chk({7'h00, o_irq}, 8'h00, "irq");
        give_verdict();
    end
endmodule : ppi_port_tb_top
